/* sfr_top.sv */
// Flash-side command path: configure write, single, fast, dual and dual-I/O reads.
// Assumes pins are asynchronous to i_clk and the array answers i_mem_data
// for o_mem_addr within three clocks.
//
// What this block does
// - Configure write ignored without write enable latch
// - Completed write-permit command sets the latch
// - Configure write needs chip select at 8 bits
// - Write cycle: busy high, then clear, latch cleared
// - Busy flag stays visible during write cycle
// - Normal read: 03, 3-byte address, no dummy
// - Sample on rising, drive on falling clock
// - Address increments per byte, wraps to zero
// - Chip select rise ends read, stops driving
// - Fast read: 0B, address, one dummy byte
// - Busy rejects fast, dual and dual-I/O reads
// - Dual-output read: 3B, 8 dummy, two bits
// - Dual-I/O: address and mode bits on two lines
// - Mode bits 10 skip next opcode
// - Other mode bits leave continuous mode
// - Continuous-mode reset command clears armed bits
`timescale 1ns/10ps
`default_nettype none
`include "sfr_consts.svh"

module sfr_top
   import sfr_pkg::*;
#(
   parameter int TW_CYCLES = `SFR_TW_US * `SFR_CLK_MHZ
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_cs_b,
   input wire logic i_sclk,
   input wire logic i_io0,
   input wire logic i_io1,
   input wire logic [7:0] i_mem_data,
   output logic o_io0,
   output logic o_io0_oe,
   output logic o_io1,
   output logic o_io1_oe,
   output logic [23:0] o_mem_addr,
   output logic o_busy,
   output logic o_wel,
   output logic o_cont_armed,
   output logic [7:0] o_cfg
);
   localparam logic [`SFR_TW_W-1:0] TW_LOAD = `SFR_TW_W'(TW_CYCLES - 1);

   sfr_core_s r_reg;
   sfr_core_s r_next;
   logic [3:0] pins_s;
   logic cs_b_s;
   logic sclk_s;
   logic io0_s;
   logic io1_s;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [23:0] sh_in;
   logic [7:0] op_in;

   sfr_sync #(.W(4)) u_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_d({i_cs_b, i_sclk, i_io1, i_io0}),
      .o_q(pins_s)
   );

   assign cs_b_s = pins_s[3];
   assign sclk_s = pins_s[2];
   assign io1_s = pins_s[1];
   assign io0_s = pins_s[0];
   assign sclk_rise = sclk_s & ~r_reg.sclk_d;
   assign sclk_fall = ~sclk_s & r_reg.sclk_d;
   assign cs_fall = ~cs_b_s & r_reg.cs_b_d;
   assign cs_rise = cs_b_s & ~r_reg.cs_b_d;
   // Input bits enter on the rising edge only
   assign sh_in = r_reg.dual_in ? {r_reg.shreg[21:0], io1_s, io0_s}
                                : {r_reg.shreg[22:0], io0_s};
   assign op_in = sh_in[7:0];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [7:0] d;
      d = r_reg.dbyte;
      r_next = r_reg;
      r_next.sclk_d = sclk_s;
      r_next.cs_b_d = cs_b_s;
      // Self-timed write cycle runs regardless of bus traffic
      if (r_reg.busy) begin
         if (r_reg.tw_cnt == '0) begin
            r_next.busy = 1'b0;
            r_next.write_enable_latch = 1'b0;
         end else begin
            r_next.tw_cnt = r_reg.tw_cnt - 1'b1;
         end
      end
      if (cs_fall) begin
         r_next.bitcnt = '0;
         r_next.shreg = '0;
         r_next.dcnt = '0;
         r_next.dual_out = 1'b0;
         if (r_reg.armed) begin
            r_next.state = ST_ADDR;
            r_next.cmd = `SFR_OP_DIO;
            r_next.dual_in = 1'b1;
            r_next.cont_acc = 1'b1;
         end else begin
            r_next.state = ST_CMD;
            r_next.dual_in = 1'b0;
            r_next.cont_acc = 1'b0;
         end
      end else if (cs_rise) begin
         r_next.state = ST_IDLE;
         r_next.oe0 = 1'b0;
         r_next.oe1 = 1'b0;
         r_next.dual_in = 1'b0;
         r_next.dual_out = 1'b0;
         if (r_reg.state == ST_TAIL && r_reg.cmd == `SFR_OP_WRITE_PERMIT_CMD
             && r_reg.bitcnt == '0 && !r_reg.busy) begin
            r_next.write_enable_latch = 1'b1;
         end
         if (r_reg.state == ST_TAIL && r_reg.cmd == `SFR_OP_CFGW
             && r_reg.bitcnt == `SFR_CFG_BITS && r_reg.write_enable_latch && !r_reg.busy) begin
            r_next.busy = 1'b1;
            r_next.tw_cnt = TW_LOAD;
            r_next.cfg = r_reg.shreg[7:0];
         end
         // All-ones on an armed access is the continuous-mode reset
         if (r_reg.state == ST_ADDR && r_reg.cont_acc && (&r_reg.shreg[7:0])) begin
            r_next.armed = 1'b0;
         end
      end else if (!cs_b_s && sclk_rise) begin
         r_next.shreg = sh_in;
         if (r_reg.bitcnt < `SFR_CNT_SAT) begin
            r_next.bitcnt = r_reg.bitcnt + (r_reg.dual_in ? 5'h02 : 5'h01);
         end
         case (r_reg.state)
            ST_CMD: begin
               if (r_reg.bitcnt == `SFR_CMD_LAST) begin
                  r_next.cmd = op_in;
                  r_next.bitcnt = '0;
                  r_next.shreg = '0;
                  case (op_in)
                     `SFR_OP_READ: r_next.state = ST_ADDR;
                     `SFR_OP_FAST, `SFR_OP_DUAL_OUTPUT_READ_CMD: begin
                        r_next.state = r_reg.busy ? ST_IGNORE : ST_ADDR;
                     end
                     `SFR_OP_DIO: begin
                        r_next.state = r_reg.busy ? ST_IGNORE : ST_ADDR;
                        r_next.dual_in = ~r_reg.busy;
                     end
                     `SFR_OP_WRITE_PERMIT_CMD, `SFR_OP_CFGW: r_next.state = ST_TAIL;
                     `SFR_OP_CRMR: begin
                        r_next.armed = 1'b0;
                        r_next.state = ST_IGNORE;
                     end
                     default: r_next.state = ST_IGNORE;
                  endcase
               end
            end
            ST_ADDR: begin
               if (r_next.bitcnt == `SFR_ADDR_BITS) begin
                  r_next.mem_addr = sh_in;
                  r_next.bitcnt = '0;
                  r_next.shreg = '0;
                  case (r_reg.cmd)
                     `SFR_OP_READ: r_next.state = ST_DATA;
                     `SFR_OP_DIO: r_next.state = ST_MODE;
                     default: r_next.state = ST_DUMMY;
                  endcase
               end
            end
            ST_MODE: begin
               if (r_next.bitcnt == `SFR_MODE_BITS) begin
                  r_next.armed = (sh_in[5:4] == `SFR_CONT_KEEP);
                  r_next.state = ST_DATA;
                  r_next.dual_out = 1'b1;
               end
            end
            ST_DUMMY: begin
               if (r_reg.bitcnt == `SFR_DUMMY_LAST) begin
                  r_next.state = ST_DATA;
                  r_next.dual_out = (r_reg.cmd == `SFR_OP_DUAL_OUTPUT_READ_CMD);
               end
            end
            default: begin
            end
         endcase
      end else if (!cs_b_s && sclk_fall && r_reg.state == ST_DATA) begin
         // Next byte is prefetched as soon as the current one is taken
         if (r_reg.dcnt == '0) begin
            d = i_mem_data;
            r_next.mem_addr = r_reg.mem_addr + 24'h00_0001;
         end
         r_next.io1 = d[7];
         r_next.oe1 = 1'b1;
         if (r_reg.dual_out) begin
            r_next.io0 = d[6];
            r_next.oe0 = 1'b1;
            r_next.dbyte = {d[5:0], 2'h0};
            r_next.dcnt = (r_reg.dcnt == '0) ? 3'h3 : r_reg.dcnt - 1'b1;
         end else begin
            r_next.dbyte = {d[6:0], 1'h0};
            r_next.dcnt = (r_reg.dcnt == '0) ? 3'h7 : r_reg.dcnt - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r_reg <= '0;
         r_reg.state <= ST_IDLE;
         r_reg.cfg <= `SFR_CFG_RST;
         r_reg.sclk_d <= 1'b1;
         r_reg.cs_b_d <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_io0 = r_reg.io0;
   assign o_io0_oe = r_reg.oe0;
   assign o_io1 = r_reg.io1;
   assign o_io1_oe = r_reg.oe1;
   assign o_mem_addr = r_reg.mem_addr;
   assign o_busy = r_reg.busy;
   assign o_wel = r_reg.write_enable_latch;
   assign o_cont_armed = r_reg.armed;
   assign o_cfg = r_reg.cfg;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence s_cfg_end;
      cs_rise && r_reg.state == ST_TAIL && r_reg.cmd == `SFR_OP_CFGW && !r_reg.busy;
   endsequence
   sequence s_load;
      !cs_b_s && sclk_fall && r_reg.state == ST_DATA && r_reg.dcnt == '0;
   endsequence

   property p_no_wel;
      s_cfg_end and (!r_reg.write_enable_latch) |=> !o_busy && o_cfg == $past(o_cfg);
   endproperty
   a_no_wel: assert property (p_no_wel) else $error("cfg write without latch");
   property p_write_permit_cmd;
      cs_rise && r_reg.state == ST_TAIL && r_reg.cmd == `SFR_OP_WRITE_PERMIT_CMD
         && r_reg.bitcnt == '0 && !r_reg.busy |=> o_wel;
   endproperty
   a_write_permit_cmd: assert property (p_write_permit_cmd) else $error("write permit did not set latch");
   property p_boundary;
      s_cfg_end and (r_reg.bitcnt != `SFR_CFG_BITS) |=> !o_busy;
   endproperty
   a_boundary: assert property (p_boundary) else $error("off-boundary cfg write ran");
   property p_start;
      s_cfg_end and (r_reg.write_enable_latch && r_reg.bitcnt == `SFR_CFG_BITS)
         |=> o_busy && o_wel && o_cfg == $past(r_reg.shreg[7:0]);
   endproperty
   a_start: assert property (p_start) else $error("write cycle did not start");
   property p_end;
      $fell(o_busy) |-> !o_wel && $past(r_reg.tw_cnt) == '0;
   endproperty
   a_end: assert property (p_end) else $error("write cycle end wrong");
   property p_reject;
      !cs_b_s && sclk_rise && !cs_rise && !cs_fall && r_reg.state == ST_CMD
         && r_reg.bitcnt == `SFR_CMD_LAST && r_reg.busy
         && (op_in == `SFR_OP_FAST || op_in == `SFR_OP_DUAL_OUTPUT_READ_CMD || op_in == `SFR_OP_DIO)
         |=> r_reg.state == ST_IGNORE && $stable(o_busy);
   endproperty
   a_reject: assert property (p_reject) else $error("read not rejected while busy");
   property p_stop;
      cs_rise |=> !o_io0_oe && !o_io1_oe && r_reg.state == ST_IDLE && !r_reg.dual_in;
   endproperty
   a_stop: assert property (p_stop) else $error("lines still driven after frame");
   property p_inc;
      s_load |=> o_mem_addr == $past(o_mem_addr) + 24'h00_0001;
   endproperty
   a_inc: assert property (p_inc) else $error("address did not advance");
   property p_fall_only;
      $changed(o_io1) |-> $past(sclk_fall);
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("data changed off falling edge");
   property p_exit;
      !cs_b_s && sclk_rise && !cs_rise && !cs_fall && r_reg.state == ST_MODE
         && r_next.bitcnt == `SFR_MODE_BITS && sh_in[5:4] != `SFR_CONT_KEEP |=> !o_cont_armed;
   endproperty
   a_exit: assert property (p_exit) else $error("continuous mode not left");
   property p_skip;
      cs_fall && r_reg.armed |=> r_reg.state == ST_ADDR && r_reg.dual_in;
   endproperty
   a_skip: assert property (p_skip) else $error("armed access expected opcode");
endmodule // sfr_top

`default_nettype wire

/* sfr_consts.svh */
// Constants for the serial flash read and configure-write command path.
// Assumes inclusion by bare name from the package and design files.
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DUAL_OUTPUT_READ_CMD 8'h3B
`define SFR_OP_DIO 8'hBB
`define SFR_OP_CFGW 8'h01
`define SFR_OP_WRITE_PERMIT_CMD 8'h06
`define SFR_OP_CRMR 8'hFF

// ----------------------------------------------------------------------
// Phase lengths in bits or clocks, bit-count limit and mode-bit keep code
// ----------------------------------------------------------------------
`define SFR_CMD_LAST 5'h07
`define SFR_ADDR_BITS 5'h18
`define SFR_CFG_BITS 5'h08
`define SFR_MODE_BITS 5'h08
`define SFR_DUMMY_LAST 5'h07
`define SFR_CNT_SAT 5'h1E
`define SFR_CONT_KEEP 2'h2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SFR_CFG_RST 8'h00
`define SFR_CLK_MHZ 25
`define SFR_TW_US 5000
`define SFR_TW_W 20

`endif

/* sfr_pkg.sv */
// Types for the serial flash command path.
// Assumes sfr_consts.svh is on the include path.
`include "sfr_consts.svh"

package sfr_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_TAIL, ST_IGNORE
   } sfr_state_e;

   typedef struct packed {
      sfr_state_e state;
      logic [4:0] bitcnt;
      logic [7:0] cmd;
      logic [23:0] shreg;
      logic [23:0] mem_addr;
      logic [7:0] dbyte;
      logic [2:0] dcnt;
      logic dual_in;
      logic dual_out;
      logic armed;
      logic cont_acc;
      logic write_enable_latch;
      logic busy;
      logic [`SFR_TW_W-1:0] tw_cnt;
      logic [7:0] cfg;
      logic io0;
      logic io1;
      logic oe0;
      logic oe1;
      logic sclk_d;
      logic cs_b_d;
   } sfr_core_s;

endpackage

/* sfr_sync.sv */
// Two-flop synchroniser for pin inputs.
// Assumes chip select idles high; reset value is all ones so no false frame starts.
`timescale 1ns/10ps
`default_nettype none

module sfr_sync #(
   parameter int W = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfr_sync_s;

   sfr_sync_s r_reg;
   sfr_sync_s r_next;

   always_comb begin
      r_next.s1 = i_d;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r_reg <= '1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign o_q = r_reg.s2;
endmodule // sfr_sync

`default_nettype wire

/* sfr_host.sv */
// Host side SPI controller model driving the flash command path pins.
// Assumes frames start on a falling i_clk edge; serial clock idles low (mode 0).
`timescale 1ns/10ps
`default_nettype none

module sfr_host (
   input wire logic i_clk,
   input wire logic i_io0,
   input wire logic i_io0_oe,
   input wire logic i_io1,
   input wire logic i_io1_oe,
   output logic o_cs_b,
   output logic o_sclk,
   output logic o_io0,
   output logic o_io1
);
   // ----
   // Line resolution
   // ----
   // Released lines show the inverse of the last bit, never a kept value
   logic h0;
   logic h1;
   assign o_io0 = i_io0_oe ? i_io0 : h0;
   assign o_io1 = i_io1_oe ? i_io1 : h1;

   initial begin
      o_cs_b = 1'b1;
      o_sclk = 1'b0;
      h0 = 1'b0;
      h1 = 1'b1;
   end

   // ----
   // Frame tasks
   // ----
   task automatic begin_frame();
      @(negedge i_clk);
      o_cs_b = 1'b0;
      #160;
   endtask

   // Data changes only while sclk is low, MSB first
   task automatic send(input logic [31:0] v, input int n, input bit dual);
      int i;
      for (i = n - 1; i >= 0; i = i - (dual ? 2 : 1)) begin
         h0 = dual ? v[i-1] : v[i];
         if (dual) h1 = v[i];
         #160 o_sclk = 1'b1;
         #160 o_sclk = 1'b0;
      end
      h0 = ~h0;
      h1 = ~h1;
   endtask

   // Sample late in the cycle: the answer lags the falling edge by up to 160 ns
   task automatic recv(output logic [7:0] b, input bit dual);
      int i;
      b = 8'h00;
      for (i = 7; i >= 0; i = i - (dual ? 2 : 1)) begin
         #160 o_sclk = 1'b1;
         #140 b[i] = o_io1;
         if (dual) b[i-1] = o_io0;
         #20 o_sclk = 1'b0;
      end
   endtask

   task automatic end_frame();
      #160 o_cs_b = 1'b1;
      #480;
   endtask
endmodule // sfr_host

`default_nettype wire

/* sfr_top_bench.sv */
// Self-checking bench for the flash command path with a host model on the pins.
// Assumes sfr_pkg and the design files compile first; array data is a function of address.
`timescale 1ns/10ps
`default_nettype none

module sfr_top_bench;
   // Short write cycle keeps the run small; still longer than one read frame
   localparam int TW = 2000;
   logic clk;
   logic rst_b;
   logic cs_b, sclk, io0, io1, io0_d, io0_oe, io1_d, io1_oe, busy, write_enable_latch, armed;
   logic [7:0] cfg;
   logic [23:0] mem_addr;
   int n_mismatch = 0;
   int n_checks = 0;

   function automatic logic [7:0] mem(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
   endfunction

   sfr_top #(.TW_CYCLES(TW)) u_dut (.i_clk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b),
      .i_sclk(sclk), .i_io0(io0), .i_io1(io1), .i_mem_data(mem(mem_addr)), .o_io0(io0_d),
      .o_io0_oe(io0_oe), .o_io1(io1_d), .o_io1_oe(io1_oe), .o_mem_addr(mem_addr),
      .o_busy(busy), .o_wel(write_enable_latch), .o_cont_armed(armed), .o_cfg(cfg));
   sfr_host u_host (.i_clk(clk), .i_io0(io0_d), .i_io0_oe(io0_oe), .i_io1(io1_d),
      .i_io1_oe(io1_oe), .o_cs_b(cs_b), .o_sclk(sclk), .o_io0(io0), .o_io1(io1));

   // ----
   // Shared tasks
   // ----
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic results();
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic cmd(input logic [7:0] op, input logic [31:0] v, input int n);
      u_host.begin_frame();
      u_host.send({24'h00_0000, op}, 8, 1'b0);
      if (n > 0) u_host.send(v, n, 1'b0);
      u_host.end_frame();
   endtask

   task automatic rd(input string nm, input bit skip_op, input logic [7:0] op,
      input logic [23:0] a, input bit din, input int dclk, input logic [7:0] mode,
      input bit dout, input int nb);
      logic [7:0] b;
      int k;
      u_host.begin_frame();
      if (!skip_op) u_host.send({24'h00_0000, op}, 8, 1'b0);
      u_host.send({8'h00, a}, 24, din);
      if (din) u_host.send({24'h00_0000, mode}, 8, 1'b1);
      else if (dclk > 0) u_host.send(32'h0000_0000, dclk, 1'b0);
      for (k = 0; k < nb; k++) begin
         u_host.recv(b, dout);
         check(nm, b, mem(24'(a + 24'(k))));
      end
      u_host.end_frame();
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_cfg();
      logic [7:0] b;
      int k;
      cmd(8'h01, 32'h0000_005a, 8);
      check("cfg_no_latch", {busy, cfg}, 9'h000);
      cmd(8'h06, 32'h0000_0000, 0);
      check("latch_set", write_enable_latch, 1'b1);
      cmd(8'h01, 32'h0000_005a, 7);
      check("cfg_short", {busy, cfg}, 9'h000);
      cmd(8'h01, 32'h0000_00a5, 8);
      check("cfg_written", {busy, cfg}, 9'h1a5);
      // Fast read while busy must leave the lines undriven
      u_host.begin_frame();
      u_host.send(32'h0000_000b, 8, 1'b0);
      u_host.send(32'h0000_0100, 32, 1'b0);
      u_host.recv(b, 1'b0);
      check("busy_read_oe", io1_oe, 1'b0);
      u_host.end_frame();
      check("busy_seen", busy, 1'b1);
      for (k = 0; k < TW + 100 && busy !== 1'b0; k++) @(negedge clk);
      check("busy_len", k > 1000, 1'b1);
      check("cycle_end", {busy, write_enable_latch}, 2'h0);
   endtask

   task automatic t_read();
      logic [7:0] b;
      rd("read_wrap", 0, 8'h03, 24'hff_fffe, 0, 0, 8'h00, 0, 3);
      u_host.begin_frame();
      u_host.send(32'h0300_0010, 32, 1'b0);
      u_host.recv(b, 1'b0);
      check("abort_byte", b, mem(24'h00_0010));
      u_host.send(32'h0000_0000, 3, 1'b0);
      u_host.end_frame();
      check("abort_oe", {io0_oe, io1_oe}, 2'h0);
      rd("fast", 0, 8'h0b, 24'h12_3456, 0, 8, 8'h00, 0, 2);
      rd("dual_out", 0, 8'h3b, 24'h00_ff00, 0, 8, 8'h00, 1, 2);
   endtask

   task automatic t_cont();
      rd("dual_io", 0, 8'hbb, 24'h65_4321, 1, 0, 8'h20, 1, 2);
      check("armed", armed, 1'b1);
      // Host that leaves continuous mode sends mode bits 00
      rd("no_opcode", 1, 8'h00, 24'h00_1000, 1, 0, 8'h00, 1, 2);
      check("disarmed", armed, 1'b0);
      rd("single_after", 0, 8'h03, 24'h00_2000, 0, 0, 8'h00, 0, 1);
      rd("rearm", 0, 8'hbb, 24'h00_3000, 1, 0, 8'hef, 1, 1);
      u_host.begin_frame();
      u_host.send(32'h0000_ffff, 16, 1'b1);
      u_host.end_frame();
      check("cont_reset", armed, 1'b0);
      rd("after_reset", 0, 8'h03, 24'h00_4000, 0, 0, 8'h00, 0, 1);
   endtask

   // ----
   // Clock, reset, sequence and watchdog
   // ----
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst_b = 1'b0;
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      check("reset_state", {cfg, busy, write_enable_latch, armed, io0_oe, io1_oe}, 13'h0000);
      t_cfg();
      t_read();
      t_cont();
      results();
   end

   // Whole sequence needs well under half a millisecond
   initial begin
      #1_000_000;
      n_mismatch++;
      results();
   end
endmodule // sfr_top_bench

`default_nettype wire
